/* File: core/sbsr_status_byte.sv */
// Status byte, service request mask, request flag and bus request line.
// Assumes summary inputs come from logic on core_clk; the poll strobe likewise.
//
// Function
// - Status byte, mask and standard event register readable by query
// - Query answer is register value, binary bits
// - Status byte and mask, both eight bits
// - Summary bits follow their messages, no latch
// - Standard event read clears, bit5 drops
// - Bits 0,3,5,7 carry enabled event summaries
// - Bit2 error queue, bit4 output message
// - Bit6 of the query byte set when enabled summary set
// - Bit6 is request flag or master summary
// - AND summaries with mask, OR together
// - Mask written 0..255, read back intact
// - Mask cleared by power-on or zero write
// - Clear status leaves mask alone
// - Enabled rising summary raises service request
// - Serial poll clears request flag
// - Same event may request again after poll
// - Poll leaves master summary until bits clear
// - Serial poll returns the poll byte
// - Power-on clears all status registers
// - Event bits latch until register reset
// - Event summary is enabled event OR
`timescale 1ns/1ps
module sbsr_status_byte
  import sbsr_pkg::*;
#(
  parameter int EVENT_WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [EVENT_WIDTH-1:0] std_event_set,
  input wire logic [EVENT_WIDTH-1:0] std_enable_wr_data,
  input wire logic std_enable_wr,
  input wire logic clear_status,
  input wire sbsr_summary_t summary_in,
  input wire logic [SBSR_WIDTH-1:0] mask_wr_data,
  input wire logic mask_wr,
  input wire logic query_rd,
  input wire logic [1:0] query_sel,
  input wire logic serial_poll,
  output logic [SBSR_WIDTH-1:0] query_data,
  output logic query_valid,
  output logic [SBSR_WIDTH-1:0] poll_data,
  output logic poll_valid,
  output logic srq_out,
  output logic srq_oe,
  output logic master_summary
);
  // The standard event register is answered through the eight-bit query path.
  if (EVENT_WIDTH < 1 || EVENT_WIDTH > SBSR_WIDTH) begin : g_bad_width
    $error("EVENT_WIDTH must lie between 1 and the status byte width.");
  end

  logic [SBSR_WIDTH-1:0] service_request_mask_reg;
  logic [EVENT_WIDTH-1:0] std_event_reg;
  logic [EVENT_WIDTH-1:0] std_enable_reg;
  logic rqs_reg;
  logic [SBSR_WIDTH-1:0] prev_enabled_reg;
  logic [SBSR_WIDTH-1:0] rise_bits;
  logic [SBSR_WIDTH-1:0] query_data_reg;
  logic query_valid_reg;
  logic [SBSR_WIDTH-1:0] poll_data_reg;
  logic poll_valid_reg;
  logic [SBSR_WIDTH-1:0] summary_bits;
  logic [SBSR_WIDTH-1:0] enabled_bits;
  logic std_summary;
  logic any_enabled;
  logic rise_enabled;
  logic std_read;
  logic [SBSR_WIDTH-1:0] status_summary_byte;
  logic [SBSR_WIDTH-1:0] poll_byte;
  logic [SBSR_WIDTH-1:0] std_event_byte;
  logic rqs_next;

  assign std_summary = |(std_event_reg & std_enable_reg);
  assign std_read = query_rd && (query_sel == SBSR_QSEL_STD);

  // Summary bits track their sources combinationally, no latch.
  assign summary_bits[SBSR_BIT_MEAS] = summary_in.measurement_summary;
  assign summary_bits[SBSR_BIT_UNUSED] = 1'b0;
  assign summary_bits[SBSR_BIT_ERR] = summary_in.error_queue_nonempty;
  assign summary_bits[SBSR_BIT_QUES] = summary_in.questionable_summary;
  assign summary_bits[SBSR_BIT_MSG] = summary_in.output_message_pending;
  assign summary_bits[SBSR_BIT_STD] = std_summary;
  assign summary_bits[SBSR_BIT_RQS] = 1'b0;
  assign summary_bits[SBSR_BIT_OPER] = summary_in.operation_summary;

  // AND with mask, OR into master summary; mask is registered so
  // a write reaches this evaluation one cycle later.
  assign enabled_bits = summary_bits & service_request_mask_reg & SBSR_SUMMARY_BITS;
  assign any_enabled = |enabled_bits;
  // One edge detector per summary bit, so a bit that rises while
  // another enabled bit already stands still raises a fresh request.
  for (genvar b = 0; b < SBSR_WIDTH; b++) begin : g_edge
    assign rise_bits[b] = enabled_bits[b] && !prev_enabled_reg[b];
  end
  assign rise_enabled = |rise_bits;

  // Poll clears the flag; a new rising edge in the poll cycle wins.
  assign rqs_next = rise_enabled ? 1'b1 : (serial_poll ? 1'b0 : rqs_reg);

  // Bit 6 is the master summary in the query byte.
  assign status_summary_byte = {summary_bits[SBSR_BIT_OPER], any_enabled,
                                summary_bits[5:0]};
  // Bit 6 is the request flag in the poll byte.
  assign poll_byte = {summary_bits[SBSR_BIT_OPER], rqs_reg, summary_bits[5:0]};
  assign std_event_byte = SBSR_WIDTH'(std_event_reg);

  // Mask only changes by reset or by its own write.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      service_request_mask_reg <= SBSR_MASK_RESET;
    end else if (mask_wr) begin
      service_request_mask_reg <= mask_wr_data;
    end
  end

  // Event bits latch; read or clear status clears, set wins.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      std_event_reg <= '0;
    end else if (std_read || clear_status) begin
      std_event_reg <= std_event_set;
    end else begin
      std_event_reg <= std_event_reg | std_event_set;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      std_enable_reg <= '0;
    end else if (std_enable_wr) begin
      std_enable_reg <= std_enable_wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rqs_reg <= 1'b0;
      prev_enabled_reg <= '0;
    end else begin
      rqs_reg <= rqs_next;
      prev_enabled_reg <= enabled_bits;
    end
  end

  logic [SBSR_WIDTH-1:0] query_mux;
  // Query answers return the plain binary register value.
  assign query_mux = (query_sel == SBSR_QSEL_STB) ? status_summary_byte :
                     (query_sel == SBSR_QSEL_MASK) ? service_request_mask_reg :
                     (query_sel == SBSR_QSEL_STD) ? std_event_byte : 8'h00;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      query_data_reg <= 8'h00;
      query_valid_reg <= 1'b0;
      poll_data_reg <= 8'h00;
      poll_valid_reg <= 1'b0;
    end else begin
      query_valid_reg <= query_rd;
      poll_valid_reg <= serial_poll;
      if (query_rd) begin
        query_data_reg <= query_mux;
      end
      if (serial_poll) begin
        poll_data_reg <= poll_byte;
      end
    end
  end

  assign query_data = query_data_reg;
  assign query_valid = query_valid_reg;
  assign poll_data = poll_data_reg;
  assign poll_valid = poll_valid_reg;
  // Open-drain request line: pull low while the flag stands.
  assign srq_out = 1'b0;
  assign srq_oe = rqs_reg;
  assign master_summary = any_enabled;

  // These guard the request flag and the bus request line.
  chk_rise_sets_rqs: assert property (
    @(posedge core_clk) disable iff (!rstn)
    rise_enabled |=> rqs_reg)
    else $error("Rising enabled summary did not set the request flag.");
  chk_poll_clears_rqs: assert property (
    @(posedge core_clk) disable iff (!rstn)
    serial_poll && !rise_enabled |=> !rqs_reg)
    else $error("Serial poll left the request flag set.");
  chk_rqs_only_rise: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !rqs_reg && !rise_enabled |=> !rqs_reg)
    else $error("Request flag set without a rising enabled summary.");
  chk_srq_cause: assert property (
    @(posedge core_clk) disable iff (!rstn)
    $rose(srq_oe) |-> $past(rise_enabled))
    else $error("Request line raised without a rising enabled summary.");
  chk_srq_hold: assert property (
    @(posedge core_clk) disable iff (!rstn)
    srq_oe && !serial_poll |=> srq_oe)
    else $error("Request line released without a serial poll.");
  chk_srq_release: assert property (
    @(posedge core_clk) disable iff (!rstn)
    serial_poll && !rise_enabled |=> !srq_oe)
    else $error("Request line still driven after a serial poll.");

  // These guard the master summary and the service request mask.
  chk_mss_after_poll: assert property (
    @(posedge core_clk) disable iff (!rstn)
    serial_poll && master_summary ##1 $stable(summary_in) && $stable(std_event_reg) &&
    $stable(service_request_mask_reg) |-> master_summary)
    else $error("Serial poll cleared the master summary.");
  chk_mss_needs_bit: assert property (
    @(posedge core_clk) disable iff (!rstn)
    master_summary |-> (summary_bits & service_request_mask_reg) != 8'h00)
    else $error("Master summary set with no enabled summary bit.");
  chk_mss_zero_mask: assert property (
    @(posedge core_clk) disable iff (!rstn)
    service_request_mask_reg == 8'h00 |-> !master_summary)
    else $error("Master summary set while the mask is clear.");
  chk_mask_write: assert property (
    @(posedge core_clk) disable iff (!rstn)
    mask_wr |=> service_request_mask_reg == $past(mask_wr_data))
    else $error("Mask write was not stored.");
  chk_mask_hold: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !mask_wr && clear_status |=> $stable(service_request_mask_reg))
    else $error("Mask changed without a write.");
  chk_mask_effect: assert property (
    @(posedge core_clk) disable iff (!rstn)
    mask_wr && mask_wr_data == 8'h00 |=> !master_summary)
    else $error("Zero mask write left the master summary set.");
  chk_mask_next_cycle: assert property (
    @(posedge core_clk) disable iff (!rstn)
    mask_wr && (summary_bits & mask_wr_data & SBSR_SUMMARY_BITS) != 8'h00
      ##1 $stable(summary_bits) |-> master_summary)
    else $error("Mask write did not reach the master summary a cycle later.");

  // These guard the standard event register.
  chk_std_read_clear: assert property (
    @(posedge core_clk) disable iff (!rstn)
    std_read && std_event_set == '0 |=> !summary_bits[SBSR_BIT_STD])
    else $error("Standard event summary survived a read.");
  chk_std_latch: assert property (
    @(posedge core_clk) disable iff (!rstn)
    std_event_set != '0 |=> (std_event_reg & $past(std_event_set)) == $past(std_event_set))
    else $error("Standard event was not latched.");
  chk_std_hold: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !std_read && !clear_status |=>
    (std_event_reg & $past(std_event_reg)) == $past(std_event_reg))
    else $error("Standard event bit dropped without a clear.");

  // These guard the poll and query answers.
  chk_poll_valid: assert property (
    @(posedge core_clk) disable iff (!rstn)
    serial_poll |=> poll_valid)
    else $error("Serial poll was not answered.");
  chk_poll_rqs_bit: assert property (
    @(posedge core_clk) disable iff (!rstn)
    serial_poll |=> poll_data[SBSR_BIT_RQS] == $past(rqs_reg))
    else $error("Poll byte bit 6 is not the request flag.");
  chk_unused_zero: assert property (
    @(posedge core_clk) disable iff (!rstn)
    poll_valid |-> !poll_data[SBSR_BIT_UNUSED])
    else $error("Unused bit set in the poll byte.");
  chk_query_pulse: assert property (
    @(posedge core_clk) disable iff (!rstn)
    query_valid == $past(query_rd))
    else $error("Query answer valid does not follow the query.");
  chk_query_stb: assert property (
    @(posedge core_clk) disable iff (!rstn)
    query_rd && query_sel == SBSR_QSEL_STB |=>
    query_valid && query_data[SBSR_BIT_RQS] == $past(any_enabled))
    else $error("Status query bit 6 is not the master summary.");
  chk_query_mask: assert property (
    @(posedge core_clk) disable iff (!rstn)
    query_rd && query_sel == SBSR_QSEL_MASK |=>
    query_data == $past(service_request_mask_reg))
    else $error("Mask query returned a wrong value.");
  chk_query_std: assert property (
    @(posedge core_clk) disable iff (!rstn)
    query_rd && query_sel == SBSR_QSEL_STD |=>
    query_data == $past(std_event_byte))
    else $error("Standard event query returned a wrong value.");
  chk_stb_queues: assert property (
    @(posedge core_clk) disable iff (!rstn)
    query_rd && query_sel == SBSR_QSEL_STB |=>
    query_data[SBSR_BIT_ERR] == $past(summary_in.error_queue_nonempty) &&
    query_data[SBSR_BIT_MSG] == $past(summary_in.output_message_pending))
    else $error("Queue bits wrong in the status query.");
  chk_stb_events: assert property (
    @(posedge core_clk) disable iff (!rstn)
    query_rd && query_sel == SBSR_QSEL_STB |=>
    query_data[SBSR_BIT_MEAS] == $past(summary_in.measurement_summary) &&
    query_data[SBSR_BIT_QUES] == $past(summary_in.questionable_summary) &&
    query_data[SBSR_BIT_OPER] == $past(summary_in.operation_summary))
    else $error("Event summary bits wrong in the status query.");
  chk_stb_unused: assert property (
    @(posedge core_clk) disable iff (!rstn)
    query_rd && query_sel == SBSR_QSEL_STB |=> !query_data[SBSR_BIT_UNUSED])
    else $error("Unused bit set in the status query.");
  chk_stb_std: assert property (
    @(posedge core_clk) disable iff (!rstn)
    query_rd && query_sel == SBSR_QSEL_STB |=>
    query_data[SBSR_BIT_STD] == $past(|(std_event_reg & std_enable_reg)))
    else $error("Standard event summary bit wrong in the status query.");
endmodule

/* File: core/sbsr_pkg.sv */
// Package for the status byte and service request block.
// Assumes one 10 MHz clock and an active-low asynchronous reset.
package sbsr_pkg;
  localparam int SBSR_WIDTH = 8;
  localparam logic [7:0] SBSR_MASK_RESET = 8'h00;
  localparam logic [7:0] SBSR_SUMMARY_BITS = 8'hBD;
  localparam int SBSR_BIT_MEAS = 0;
  localparam int SBSR_BIT_UNUSED = 1;
  localparam int SBSR_BIT_ERR = 2;
  localparam int SBSR_BIT_QUES = 3;
  localparam int SBSR_BIT_MSG = 4;
  localparam int SBSR_BIT_STD = 5;
  localparam int SBSR_BIT_RQS = 6;
  localparam int SBSR_BIT_OPER = 7;
  localparam logic [1:0] SBSR_QSEL_STB = 2'h0;
  localparam logic [1:0] SBSR_QSEL_MASK = 2'h1;
  localparam logic [1:0] SBSR_QSEL_STD = 2'h2;

  typedef struct packed {
    logic operation_summary;
    logic standard_event_summary;
    logic output_message_pending;
    logic questionable_summary;
    logic error_queue_nonempty;
    logic measurement_summary;
  } sbsr_summary_t;
endpackage

/* File: testbench/sbsr_poll_ctl.sv */
// Bus controller model that serial polls the device when the bench asks.
// Assumes the device answers a poll strobe with a one-cycle valid.
`timescale 1ns/1ps
module sbsr_poll_ctl (
  input wire logic core_clk,
  input wire logic poll_go,
  input wire logic poll_valid,
  input wire logic [7:0] poll_data,
  output logic serial_poll,
  output logic [7:0] poll_byte
);
  initial serial_poll = 1'b0;
  initial poll_byte = 8'h00;
  always @(posedge core_clk) serial_poll <= poll_go & ~serial_poll;
  always @(posedge core_clk) if (poll_valid) poll_byte <= poll_data;
endmodule

/* File: testbench/test_status_byte_service_request.sv */
// Bench for the status byte block: random stimulus checked against an integer model.
// Assumes the poll controller model in sbsr_poll_ctl.sv.
`timescale 1ns/1ps
module test_status_byte_service_request;
  import sbsr_pkg::*;
  logic core_clk, rstn, std_enable_wr, clear_status, mask_wr, query_rd, poll_go;
  logic serial_poll, query_valid, poll_valid, srq_out, srq_oe, master_summary;
  logic [7:0] std_event_set, std_enable_wr_data, mask_wr_data, query_data, poll_data, poll_byte;
  logic [1:0] query_sel;
  sbsr_summary_t summary_in;
  logic [31:0] seed = 32'h4E70391F;
  logic [31:0] r;
  int error_cnt = 0, check_count = 0, mask = 0, sev = 0, sen = 0, rqs = 0, pm = 0, m, e, v;
  sbsr_status_byte sbsr_status_byte_i (.core_clk, .rstn, .std_event_set, .std_enable_wr_data,
    .std_enable_wr, .clear_status, .summary_in, .mask_wr_data, .mask_wr, .query_rd, .query_sel,
    .serial_poll, .query_data, .query_valid, .poll_data, .poll_valid, .srq_out, .srq_oe,
    .master_summary);
  sbsr_poll_ctl sbsr_poll_ctl_i (.core_clk, .poll_go, .poll_valid, .poll_data, .serial_poll,
    .poll_byte);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Status byte as the model sees it, bit 6 left clear.
  function automatic int sb();
    return {summary_in.operation_summary, 1'b0, (sev & sen) != 0,
      summary_in.output_message_pending, summary_in.questionable_summary,
      summary_in.error_queue_nonempty, 1'b0, summary_in.measurement_summary};
  endfunction
  task automatic chk(input logic [8:0] got, input int exp);
    check_count++;
    if (got !== 9'(exp)) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, 9'(exp));
    end
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    error_cnt++;
    finish_test();
  end
  initial begin
    {rstn, std_enable_wr, clear_status, mask_wr, query_rd, poll_go} = '0;
    {std_event_set, std_enable_wr_data, mask_wr_data, query_sel} = '0;
    summary_in = '0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    chk({srq_out, srq_oe, master_summary}, 0);
    for (int i = 0; i < 300; i++) begin
      r = rnd();
      e = rnd();
      @(posedge core_clk);
      std_event_set <= r[15:8] & {8{r[6]}};
      std_enable_wr <= r[7];
      std_enable_wr_data <= r[23:16];
      mask_wr <= r[24];
      mask_wr_data <= r[25] ? e[7:0] : 8'h00;
      clear_status <= r[26] & r[27];
      @(posedge core_clk);
      {std_event_set, std_enable_wr, mask_wr, clear_status} <= '0;
      summary_in <= r[5:0];
      if (r[26] & r[27]) sev = 0;
      sev = sev | (r[6] ? r[15:8] : 0);
      if (r[7]) sen = r[23:16];
      if (r[24]) mask = r[25] ? e[7:0] : 0;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      v = sb() & mask;
      m = v != 0;
      if ((v & ~pm) != 0) rqs = 1;
      pm = v;
      chk({srq_out, srq_oe, master_summary}, rqs * 2 + m);
      @(posedge core_clk);
      query_rd <= 1'b1;
      query_sel <= r[29:28];
      @(posedge core_clk);
      query_rd <= 1'b0;
      e = r[29:28] == 0 ? sb() | m << 6 : r[29:28] == 1 ? mask : r[29:28] == 2 ? sev : 0;
      @(negedge core_clk);
      chk({query_valid, query_data}, 256 + e);
      if (r[29:28] == 2) sev = 0;
      pm = sb() & mask;
      m = pm != 0;
      if (r[30]) begin
        e = sb() | rqs << 6;
        @(posedge core_clk);
        poll_go <= 1'b1;
        @(posedge core_clk);
        poll_go <= 1'b0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk({1'b0, poll_byte}, e);
        rqs = 0;
        chk({srq_out, srq_oe, master_summary}, m);
      end
    end
    // A second power-on after the random run must clear the mask and the request.
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    {mask, sev, sen, rqs, pm} = '0;
    @(negedge core_clk);
    chk({srq_out, srq_oe, master_summary}, 0);
    @(posedge core_clk);
    query_rd <= 1'b1;
    query_sel <= SBSR_QSEL_MASK;
    @(posedge core_clk);
    query_rd <= 1'b0;
    @(negedge core_clk);
    chk({query_valid, query_data}, 256);
    finish_test();
  end
endmodule
